// ### src/exec_pkg.sv
package exec_pkg;

  localparam int PC_W     = 16;
  localparam int OFFSET_W = 7;
  localparam int DISP_W   = 6;

  localparam logic [7:0] OFF_CMD       = 8'h00;
  localparam logic [7:0] OFF_ADDR      = 8'h04;
  localparam logic [7:0] OFF_PC        = 8'h08;
  localparam logic [7:0] OFF_FLAGS     = 8'h0c;
  localparam logic [7:0] OFF_STATUS    = 8'h10;
  localparam logic [7:0] OFF_REG_INDEX = 8'h14;
  localparam logic [7:0] OFF_REG_DATA  = 8'h18;

  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam int STAT_BUSY   = 0;
  localparam int STAT_TAKEN  = 1;
  localparam int STAT_CYC_LO = 2;
  localparam int STAT_CYC_HI = 3;

  localparam logic [1:0] PTR_FIRST  = 2'h0;
  localparam logic [1:0] PTR_SECOND = 2'h1;
  localparam logic [1:0] PTR_THIRD  = 2'h2;
  localparam logic [4:0] PTR_FIRST_LO  = 5'h1a;
  localparam logic [4:0] PTR_SECOND_LO = 5'h1c;
  localparam logic [4:0] PTR_THIRD_LO  = 5'h1e;

  localparam logic [15:0] ONE16   = 16'h0001;
  localparam logic [1:0]  CYC_ONE = 2'h1;
  localparam logic [1:0]  CYC_TWO = 2'h2;

  typedef enum logic [4:0] {
    OP_NONE                        = 5'h00,
    OP_BRANCH_SIGNED_LESS          = 5'h01,
    OP_BRANCH_SIGNED_GREATER_EQUAL = 5'h02,
    OP_BRANCH_HALF_CARRY_SET       = 5'h03,
    OP_BRANCH_HALF_CARRY_CLEAR     = 5'h04,
    OP_BRANCH_TRANSFER_BIT_SET     = 5'h05,
    OP_BRANCH_IRQ_ENABLED          = 5'h06,
    OP_BRANCH_IRQ_DISABLED         = 5'h07,
    OP_REGISTER_COPY               = 5'h08,
    OP_REGISTER_PAIR_COPY          = 5'h09,
    OP_LOAD_CONSTANT               = 5'h0a,
    OP_LOAD_VIA_POINTER            = 5'h0b,
    OP_LOAD_VIA_POINTER_INC        = 5'h0c,
    OP_LOAD_VIA_POINTER_DEC        = 5'h0d,
    OP_LOAD_WITH_OFFSET            = 5'h0e,
    OP_LOAD_DIRECT                 = 5'h0f,
    OP_STORE_VIA_POINTER           = 5'h10,
    OP_STORE_VIA_POINTER_INC       = 5'h11
  } op_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_JUMP = 2'b10,
    S_MEM  = 2'b11
  } state_type;

  typedef struct packed {
    logic [7:0] imm;
    logic [6:0] spare;
    logic [1:0] ptr;
    logic [4:0] src;
    logic [4:0] dst;
    op_type     op;
  } cmd_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } mem_req_type;

  function automatic logic is_branch(input op_type op);
    return (op >= OP_BRANCH_SIGNED_LESS) && (op <= OP_BRANCH_IRQ_DISABLED);
  endfunction : is_branch

endpackage : exec_pkg

// ### src/branch_judge.sv
`timescale 1ns/1ps
`default_nettype none
module branch_judge
  import exec_pkg::*;
(
  // Command and machine state
  input  wire op_type      op,
  input  wire logic [7:0]  flags,
  input  wire logic [15:0] program_counter,
  input  wire logic [7:0]  imm,
  // Decision
  output logic             taken,
  output logic [15:0]      target
);

  logic [15:0] offset_ext;

  // Offset is signed so that backward jumps work.
  assign offset_ext = {{(PC_W - OFFSET_W){imm[OFFSET_W-1]}}, imm[OFFSET_W-1:0]};
  assign target     = program_counter + offset_ext + ONE16;

  always_comb begin
    case (op)
      OP_BRANCH_SIGNED_LESS:          taken = flags[FLAG_N] ^ flags[FLAG_V];
      OP_BRANCH_SIGNED_GREATER_EQUAL: taken = ~(flags[FLAG_N] ^ flags[FLAG_V]);
      OP_BRANCH_HALF_CARRY_SET:       taken = flags[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR:     taken = ~flags[FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET:     taken = flags[FLAG_T];
      OP_BRANCH_IRQ_ENABLED:          taken = flags[FLAG_I];
      OP_BRANCH_IRQ_DISABLED:         taken = ~flags[FLAG_I];
      default:                        taken = 1'b0;
    endcase
  end

endmodule : branch_judge
`default_nettype wire

// ### src/branch_load_store_exec.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Signed-less branch jumps to counter plus offset plus one when N xor V is one.
// - Signed greater-or-equal branch jumps when N xor V is zero.
// - Half-carry-set branch jumps when the half carry flag is one.
// - Half-carry-clear branch jumps when the half carry flag is zero.
// - Transfer-bit-set branch jumps when the transfer flag is one.
// - Interrupts-enabled branch jumps when the interrupt enable flag is one.
// - Interrupts-disabled branch jumps when the interrupt enable flag is zero.
// - Register copy, pair copy and constant load finish in one clock, flags untouched.
// - Pointer load reads memory at the pointer in two clocks; increment form adds one.
// - Decrement load first lowers the pointer, then reads the new address.
// - Offset load reads second or third pointer plus displacement; pointer stays.
// - Direct load reads the given address into the destination in two clocks.
// - Pointer store writes the source register at the pointer; increment form adds one.
module branch_load_store_exec
  import exec_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Data memory, read data valid while re is high
  output mem_req_type      mem_req,
  input  wire logic [7:0]  mem_rdata
);

  typedef struct packed {
    state_type        state;
    cmd_type          cmd;
    logic [15:0]      direct_addr;
    logic [15:0]      program_counter;
    logic [7:0]       flags;
    logic [15:0]      target;
    logic [1:0]       cycles;
    logic             taken;
    logic [4:0]       reg_index;
    logic [31:0][7:0] regs;
    mem_req_type      mem;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } core_type;

  core_type    core;
  core_type    next_core;
  logic        taken;
  logic [15:0] target;
  logic        access;
  logic        busy;

  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    if (sel == PTR_FIRST) begin
      return PTR_FIRST_LO;
    end else if (sel == PTR_SECOND) begin
      return PTR_SECOND_LO;
    end else begin
      return PTR_THIRD_LO;
    end
  endfunction : ptr_lo

  function automatic logic [15:0] ptr_read(input logic [31:0][7:0] regs,
                                           input logic [1:0] sel);
    logic [4:0] lo;
    lo = ptr_lo(sel);
    return {regs[{lo[4:1], 1'b1}], regs[lo]};
  endfunction : ptr_read

  branch_judge u_judge (
    .op              (core.cmd.op),
    .flags           (core.flags),
    .program_counter (core.program_counter),
    .imm             (core.cmd.imm),
    .taken           (taken),
    .target          (target)
  );

  assign access = psel && penable && !core.pready;
  assign busy   = (core.state != S_IDLE);

  always_comb begin
    logic [4:0]  lo;
    logic [15:0] ptr;
    logic [1:0]  sel;
    lo = '0;
    ptr = '0;
    sel = '0;
    next_core = core;
    next_core.pready = 1'b0;
    next_core.pslverr = 1'b0;
    next_core.mem.we = 1'b0;
    next_core.mem.re = 1'b0;

    // One wait state keeps every APB output on a flip-flop.
    if (access) begin
      next_core.pready = 1'b1;
      next_core.prdata = '0;
      if (pwrite) begin
        // Writes while a command runs would race the executor, so refuse them.
        if (busy) begin
          next_core.pslverr = 1'b1;
        end else if (paddr == OFF_CMD) begin
          next_core.cmd = cmd_type'(pwdata);
          next_core.state = S_EXEC;
        end else if (paddr == OFF_ADDR) begin
          next_core.direct_addr = pwdata[15:0];
        end else if (paddr == OFF_PC) begin
          next_core.program_counter = pwdata[15:0];
        end else if (paddr == OFF_FLAGS) begin
          next_core.flags = pwdata[7:0];
        end else if (paddr == OFF_REG_INDEX) begin
          next_core.reg_index = pwdata[4:0];
        end else if (paddr == OFF_REG_DATA) begin
          next_core.regs[core.reg_index] = pwdata[7:0];
        end else if (paddr != OFF_STATUS) begin
          next_core.pslverr = 1'b1;
        end
      end else begin
        if (paddr == OFF_CMD) begin
          next_core.prdata = core.cmd;
        end else if (paddr == OFF_ADDR) begin
          next_core.prdata[15:0] = core.direct_addr;
        end else if (paddr == OFF_PC) begin
          next_core.prdata[15:0] = core.program_counter;
        end else if (paddr == OFF_FLAGS) begin
          next_core.prdata[7:0] = core.flags;
        end else if (paddr == OFF_STATUS) begin
          next_core.prdata[STAT_BUSY] = busy;
          next_core.prdata[STAT_TAKEN] = core.taken;
          next_core.prdata[STAT_CYC_HI:STAT_CYC_LO] = core.cycles;
        end else if (paddr == OFF_REG_INDEX) begin
          next_core.prdata[4:0] = core.reg_index;
        end else if (paddr == OFF_REG_DATA) begin
          next_core.prdata[7:0] = core.regs[core.reg_index];
        end else begin
          next_core.pslverr = 1'b1;
        end
      end
    end

    sel = core.cmd.ptr;
    if (core.cmd.op == OP_LOAD_WITH_OFFSET && sel == PTR_FIRST) begin
      sel = PTR_SECOND;
    end
    lo = ptr_lo(sel);
    ptr = ptr_read(core.regs, sel);

    case (core.state)
      S_IDLE: begin
      end
      S_EXEC: begin
        next_core.cycles = CYC_ONE;
        next_core.taken = 1'b0;
        next_core.state = S_MEM;
        next_core.mem.addr = ptr;
        if (is_branch(core.cmd.op)) begin
          if (taken) begin
            next_core.target = target;
            next_core.taken = 1'b1;
            next_core.state = S_JUMP;
          end else begin
            next_core.program_counter = core.program_counter + ONE16;
            next_core.state = S_IDLE;
          end
        end else begin
          case (core.cmd.op)
            OP_LOAD_VIA_POINTER, OP_LOAD_VIA_POINTER_INC: begin
              next_core.mem.re = 1'b1;
            end
            OP_LOAD_VIA_POINTER_DEC: begin
              next_core.mem.addr = ptr - ONE16;
              next_core.mem.re = 1'b1;
              {next_core.regs[{lo[4:1], 1'b1}], next_core.regs[lo]} = ptr - ONE16;
            end
            OP_LOAD_WITH_OFFSET: begin
              next_core.mem.addr = ptr + {{(PC_W - DISP_W){1'b0}}, core.cmd.imm[DISP_W-1:0]};
              next_core.mem.re = 1'b1;
            end
            OP_LOAD_DIRECT: begin
              next_core.mem.addr = core.direct_addr;
              next_core.mem.re = 1'b1;
            end
            OP_STORE_VIA_POINTER, OP_STORE_VIA_POINTER_INC: begin
              next_core.mem.wdata = core.regs[core.cmd.src];
              next_core.mem.we = 1'b1;
            end
            default: begin
              // Register moves complete here and never touch the flags.
              next_core.state = S_IDLE;
              next_core.program_counter = core.program_counter + ONE16;
              if (core.cmd.op == OP_REGISTER_COPY) begin
                next_core.regs[core.cmd.dst] = core.regs[core.cmd.src];
              end else if (core.cmd.op == OP_REGISTER_PAIR_COPY) begin
                next_core.regs[{core.cmd.dst[4:1], 1'b0}] = core.regs[{core.cmd.src[4:1], 1'b0}];
                next_core.regs[{core.cmd.dst[4:1], 1'b1}] = core.regs[{core.cmd.src[4:1], 1'b1}];
              end else if (core.cmd.op == OP_LOAD_CONSTANT) begin
                next_core.regs[core.cmd.dst] = core.cmd.imm;
              end
            end
          endcase
        end
      end
      S_JUMP: begin
        next_core.program_counter = core.target;
        next_core.cycles = CYC_TWO;
        next_core.state = S_IDLE;
      end
      S_MEM: begin
        next_core.cycles = CYC_TWO;
        next_core.state = S_IDLE;
        next_core.program_counter = core.program_counter + ONE16;
        if (core.mem.re) begin
          next_core.regs[core.cmd.dst] = mem_rdata;
        end
        // The pointer update comes last so it wins over a load into the pointer.
        if (core.cmd.op == OP_LOAD_VIA_POINTER_INC ||
            core.cmd.op == OP_STORE_VIA_POINTER_INC) begin
          {next_core.regs[{lo[4:1], 1'b1}], next_core.regs[lo]} = ptr + ONE16;
        end
      end
      default: begin
        next_core.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  assign pready  = core.pready;
  assign prdata  = core.prdata;
  assign pslverr = core.pslverr;
  assign mem_req = core.mem;

  logic        exec;
  logic        nv;
  logic [15:0] off_ext;
  logic [15:0] cur_ptr;

  assign exec    = (core.state == S_EXEC);
  assign nv      = core.flags[FLAG_N] ^ core.flags[FLAG_V];
  assign off_ext = {{(PC_W - OFFSET_W){core.cmd.imm[OFFSET_W-1]}}, core.cmd.imm[OFFSET_W-1:0]};
  assign cur_ptr = ptr_read(core.regs, core.cmd.ptr);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LESS_TARGET: assert property (
    exec && core.cmd.op == OP_BRANCH_SIGNED_LESS && nv |->
      ##2 core.program_counter == $past(core.program_counter, 2) + $past(off_ext, 2) + ONE16)
    else $error("signed-less branch landed at wrong address");

  AST_GE_DECIDE: assert property (
    exec && core.cmd.op == OP_BRANCH_SIGNED_GREATER_EQUAL |=>
      core.state == ($past(nv) ? S_IDLE : S_JUMP))
    else $error("greater-or-equal branch decided wrongly");

  AST_HALF_DECIDE: assert property (
    exec && (core.cmd.op == OP_BRANCH_HALF_CARRY_SET ||
             core.cmd.op == OP_BRANCH_HALF_CARRY_CLEAR) |=>
      core.taken == ($past(core.flags[FLAG_H]) == ($past(core.cmd.op) == OP_BRANCH_HALF_CARRY_SET)))
    else $error("half carry branch decided wrongly");

  AST_TBIT_DECIDE: assert property (
    exec && core.cmd.op == OP_BRANCH_TRANSFER_BIT_SET |=> core.taken == $past(core.flags[FLAG_T]))
    else $error("transfer bit branch decided wrongly");

  AST_IRQ_DECIDE: assert property (
    exec && (core.cmd.op == OP_BRANCH_IRQ_ENABLED || core.cmd.op == OP_BRANCH_IRQ_DISABLED) |=>
      core.taken == ($past(core.flags[FLAG_I]) == ($past(core.cmd.op) == OP_BRANCH_IRQ_ENABLED)))
    else $error("interrupt flag branch decided wrongly");

  AST_MOVE_ONE_CLOCK: assert property (
    exec && (core.cmd.op == OP_REGISTER_COPY || core.cmd.op == OP_LOAD_CONSTANT) |=>
      core.state == S_IDLE && core.flags == $past(core.flags) &&
      core.regs[core.cmd.dst] == ($past(core.cmd.op) == OP_LOAD_CONSTANT ?
                                  core.cmd.imm : $past(core.regs[core.cmd.src])))
    else $error("register move wrong or slow");

  AST_LOAD_INC: assert property (
    exec && core.cmd.op == OP_LOAD_VIA_POINTER_INC && core.cmd.dst < PTR_FIRST_LO |->
      ##1 (mem_req.re && mem_req.addr == $past(cur_ptr)) ##1
      (cur_ptr == $past(cur_ptr, 2) + ONE16 && core.state == S_IDLE))
    else $error("post-increment load wrong");

  AST_LOAD_DEC: assert property (
    exec && core.cmd.op == OP_LOAD_VIA_POINTER_DEC |=>
      mem_req.re && mem_req.addr == $past(cur_ptr) - ONE16)
    else $error("pre-decrement load used wrong address");

  AST_LOAD_DIRECT: assert property (
    exec && core.cmd.op == OP_LOAD_DIRECT |=> mem_req.re && mem_req.addr == $past(core.direct_addr)
      ##1 core.regs[core.cmd.dst] == $past(mem_rdata))
    else $error("direct load wrong");

  AST_STORE: assert property (
    exec && core.cmd.op == OP_STORE_VIA_POINTER |=>
      mem_req.we && mem_req.addr == $past(cur_ptr) && mem_req.wdata == $past(core.regs[core.cmd.src]))
    else $error("store drove wrong address or data");

  AST_NOT_TAKEN_ONE: assert property (
    exec && is_branch(core.cmd.op) && !taken |=> core.state == S_IDLE && core.cycles == CYC_ONE)
    else $error("untaken branch did not finish in one clock");

  COV_TAKEN: cover property (core.state == S_JUMP ##1 core.state == S_IDLE);
  COV_LOAD: cover property (exec && core.cmd.op == OP_LOAD_WITH_OFFSET ##2 core.state == S_IDLE);
  COV_STORE_INC: cover property (exec && core.cmd.op == OP_STORE_VIA_POINTER_INC);
  COV_REFUSED: cover property (pslverr && pready);

endmodule : branch_load_store_exec
`default_nettype wire

// ### bench/data_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module data_memory_model
  import exec_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Memory side of the executor
  input  wire mem_req_type mem_req,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] last;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
    last = 8'h00;
  end

  always @(posedge pclk) begin
    if (mem_req.we) begin
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
    end
    if (mem_req.re) begin
      last <= mem[mem_req.addr[7:0]];
    end
  end

  // Outside a read the bus shows the inverse of the last value, so a stale sample is caught.
  assign mem_rdata = mem_req.re ? mem[mem_req.addr[7:0]] : ~last;
endmodule : data_memory_model
`default_nettype wire

// ### bench/tb_branch_load_store_exec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_branch_load_store_exec;
  import exec_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  mem_req_type mem_req;
  logic [7:0]  mem_rdata;
  int          mismatches;
  int          cmp_count;
  int          cycles;
  logic        last_err;
  logic [31:0] rv;

  branch_load_store_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata));
  data_memory_model u_mem (.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // A hung access would otherwise stall forever; the run needs well under this.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout may end this wait.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic set_reg(input logic [4:0] i, input logic [7:0] v);
    wr(OFF_REG_INDEX, {27'h0, i});
    wr(OFF_REG_DATA, {24'h0, v});
  endtask : set_reg

  task automatic reg_is(input logic [4:0] i, input logic [7:0] v);
    wr(OFF_REG_INDEX, {27'h0, i});
    rd(OFF_REG_DATA);
    check(rv, {24'h0, v});
  endtask : reg_is

  // Issues one command and polls busy, then checks the status word it left.
  task automatic run(input op_type op, input logic [4:0] dst, input logic [4:0] src,
                     input logic [1:0] ptr, input logic [7:0] imm, input logic [3:0] stat);
    int n;
    wr(OFF_CMD, {imm, 7'h00, ptr, src, dst, op});
    n = 0;
    do begin
      rd(OFF_STATUS);
      n++;
    end while (rv[STAT_BUSY] !== 1'b0 && n < 20);
    check(rv, {28'h0, stat});
  endtask : run

  op_type      bop [7] = '{OP_BRANCH_SIGNED_LESS, OP_BRANCH_SIGNED_GREATER_EQUAL,
                           OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR,
                           OP_BRANCH_TRANSFER_BIT_SET, OP_BRANCH_IRQ_ENABLED,
                           OP_BRANCH_IRQ_DISABLED};
  logic [7:0]  ftrue [7] = '{8'h04, 8'h0c, 8'h20, 8'h00, 8'h40, 8'h80, 8'h00};
  logic [7:0]  ffalse [7] = '{8'h0c, 8'h04, 8'h00, 8'h20, 8'h00, 8'h00, 8'h80};

  initial begin
    logic [7:0]  off;
    logic [15:0] exp_pc;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Each branch once with its condition true and once false, offsets both ways.
    for (int i = 0; i < 7; i++) begin
      for (int t = 0; t < 2; t++) begin
        off = (i % 2 == 0) ? 8'h7e : 8'h05;
        wr(OFF_PC, 32'h0000_0100);
        wr(OFF_FLAGS, {24'h0, (t == 0) ? ftrue[i] : ffalse[i]});
        run(bop[i], 5'h00, 5'h00, 2'h0, off, (t == 0) ? 4'ha : 4'h4);
        exp_pc = (t == 0) ? 16'h0100 + {{9{off[6]}}, off[6:0]} + 16'h0001 : 16'h0101;
        rd(OFF_PC);
        check(rv, {16'h0, exp_pc});
      end
    end
    $display("test branches done");
    wr(OFF_FLAGS, 32'h0000_00ec);
    set_reg(5'd5, 8'h77);
    set_reg(5'd6, 8'h11);
    set_reg(5'd7, 8'h22);
    run(OP_REGISTER_COPY, 5'd3, 5'd5, 2'h0, 8'h00, 4'h4);
    reg_is(5'd3, 8'h77);
    run(OP_REGISTER_PAIR_COPY, 5'd12, 5'd6, 2'h0, 8'h00, 4'h4);
    reg_is(5'd12, 8'h11);
    reg_is(5'd13, 8'h22);
    run(OP_LOAD_CONSTANT, 5'd16, 5'd0, 2'h0, 8'h9b, 4'h4);
    reg_is(5'd16, 8'h9b);
    rd(OFF_FLAGS);
    check(rv, 32'h0000_00ec);
    $display("test moves done");
    set_reg(5'd26, 8'h40);
    set_reg(5'd27, 8'h00);
    run(OP_LOAD_VIA_POINTER, 5'd1, 5'd0, 2'h0, 8'h00, 4'h8);
    reg_is(5'd1, 8'h40 ^ 8'ha5);
    reg_is(5'd26, 8'h40);
    run(OP_LOAD_VIA_POINTER_INC, 5'd2, 5'd0, 2'h0, 8'h00, 4'h8);
    reg_is(5'd2, 8'h40 ^ 8'ha5);
    reg_is(5'd26, 8'h41);
    set_reg(5'd28, 8'h30);
    set_reg(5'd29, 8'h00);
    run(OP_LOAD_VIA_POINTER_DEC, 5'd3, 5'd0, 2'h1, 8'h00, 4'h8);
    reg_is(5'd3, 8'h2f ^ 8'ha5);
    reg_is(5'd28, 8'h2f);
    set_reg(5'd30, 8'h50);
    set_reg(5'd31, 8'h00);
    run(OP_LOAD_WITH_OFFSET, 5'd4, 5'd0, 2'h2, 8'h3f, 4'h8);
    reg_is(5'd4, 8'h8f ^ 8'ha5);
    reg_is(5'd30, 8'h50);
    wr(OFF_ADDR, 32'h0000_00a7);
    run(OP_LOAD_DIRECT, 5'd5, 5'd0, 2'h0, 8'h00, 4'h8);
    reg_is(5'd5, 8'ha7 ^ 8'ha5);
    $display("test loads done");
    set_reg(5'd26, 8'h60);
    set_reg(5'd9, 8'h3c);
    set_reg(5'd10, 8'hc3);
    run(OP_STORE_VIA_POINTER, 5'd0, 5'd9, 2'h0, 8'h00, 4'h8);
    check({24'h0, u_mem.mem[8'h60]}, 32'h0000_003c);
    reg_is(5'd26, 8'h60);
    run(OP_STORE_VIA_POINTER_INC, 5'd0, 5'd10, 2'h0, 8'h00, 4'h8);
    check({24'h0, u_mem.mem[8'h60]}, 32'h0000_00c3);
    reg_is(5'd26, 8'h61);
    $display("test stores done");
    wr(OFF_PC, 32'h0000_0200);
    run(OP_NONE, 5'h00, 5'h00, 2'h0, 8'h00, 4'h4);
    rd(OFF_PC);
    check(rv, 32'h0000_0201);
    wr(OFF_STATUS, 32'h0000_000f);
    check({31'h0, last_err}, 32'h0000_0000);
    rd(OFF_STATUS);
    check(rv, 32'h0000_0004);
    rd(8'h1c);
    check({31'h0, last_err}, 32'h0000_0001);
    rd(OFF_STATUS);
    check({31'h0, last_err}, 32'h0000_0000);
    $display("test bus errors done");
    close_out();
  end
endmodule : tb_branch_load_store_exec
`default_nettype wire
